// ==== common/dcp_pkg.sv ====
package dcp_pkg;

   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [5:0] OFF_DST_ADDR = 6'h00;
   localparam logic [5:0] OFF_SRC_SIZE = 6'h04;
   localparam logic [5:0] OFF_DST_SIZE = 6'h08;
   localparam logic [5:0] OFF_SRC_PTR = 6'h0c;
   localparam logic [5:0] OFF_DST_PTR = 6'h10;
   localparam logic [5:0] OFF_CELL_SIZE = 6'h14;
   localparam logic [5:0] OFF_CELL_PTR = 6'h18;
   localparam logic [5:0] OFF_MATCH = 6'h1c;
   localparam logic [5:0] OFF_CTRL = 6'h20;
   localparam logic [5:0] OFF_STATUS = 6'h24;
   localparam logic [5:0] OFF_MASK = 6'h28;

   // Control register fields.
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_PAT_BIT = 1;
   localparam int CTRL_START_BIT = 2;
   localparam int CTRL_STEP_LSB = 4;

   // Status flag positions.
   localparam int FLG_SRC_DONE = 7;
   localparam int FLG_SRC_HALF = 6;
   localparam int FLG_DST_DONE = 5;
   localparam int FLG_DST_HALF = 4;
   localparam int FLG_BLOCK = 3;
   localparam int FLG_CELL = 2;
   localparam int NUM_FLAGS = 8;

   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [2:0] STEP_RESET = 3'h1;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } dcp_resp_t;

   // Software-visible configuration handed to the pointer engine.
   typedef struct packed {
      logic enable;
      logic pat_mode;
      logic [2:0] step;
      logic [7:0] match_byte;
      logic [15:0] src_byte_count;
      logic [15:0] dst_byte_count;
      logic [15:0] bytes_per_event;
   } dcp_cfg_t;

   // Progress state returned by the pointer engine.
   typedef struct packed {
      logic [15:0] src_progress;
      logic [15:0] dst_progress;
      logic [15:0] cell_progress;
      logic busy;
   } dcp_prog_t;

endpackage

// ==== dv/dcp_channel_checker.sv ====
`timescale 1ns/1ps
module dcp_channel_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] araddr,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   // Data path and outputs
   input wire logic beat_done,
   input wire logic [31:0] dst_addr,
   input wire logic xfer_active,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic wr_hs;
   logic [5:0] ra_ff;
   logic [31:0] wd_ff;
   logic [16:0] csz_ff;
   logic [16:0] cnt_ff;
   logic [2:0] st_ff;
   logic [7:0] msk_ff;
   logic pat_ff;
   assign wr_hs = awvalid && awready && wvalid && wready;
   // Shadows assume full-word strobes and address offered with data, as the bench does on every shadowed register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ra_ff <= 6'h00;
         wd_ff <= 32'h0;
         csz_ff <= 17'h10000;
         cnt_ff <= 17'h0;
         st_ff <= 3'h1;
         msk_ff <= 8'h00;
         pat_ff <= 1'b0;
      end else begin
         if (arvalid && arready) ra_ff <= araddr[5:0];
         if (wr_hs) wd_ff <= wdata;
         if (wr_hs && awaddr[5:0] == dcp_pkg::OFF_CELL_SIZE) begin
            csz_ff <= {wdata[15:0] == 16'h0, wdata[15:0]};
         end
         if (wr_hs && awaddr[5:0] == dcp_pkg::OFF_CTRL) begin
            st_ff <= (wdata[6:4] == 3'h0) ? 3'h1 : wdata[6:4];
            pat_ff <= wdata[1];
         end
         if (wr_hs && awaddr[5:0] == dcp_pkg::OFF_MASK) msk_ff <= wdata[7:0];
         cnt_ff <= xfer_active ? cnt_ff + (beat_done ? 17'(st_ff) : 17'h0) : 17'h0;
      end
   end
   a_write_answer: assert property (wr_hs |-> ##[1:3] bvalid)
      else $error("write response missing");
   a_dst_follow: assert property (wr_hs && awaddr[5:0] == dcp_pkg::OFF_DST_ADDR
      |=> ##[0:2] dst_addr == wd_ff)
      else $error("destination address not taken");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_read_block: assert property (rvalid |-> !arready)
      else $error("read accepted while busy");
   a_upper_zero: assert property (rvalid && ra_ff inside {[6'h04:6'h18]}
      |-> rdata[31:16] == 16'h0)
      else $error("upper half not zero");
   a_cell_end: assert property (xfer_active && beat_done && !pat_ff && cnt_ff + 17'(st_ff) >= csz_ff
      |=> ##[0:1] !xfer_active)
      else $error("cell did not end");
   a_mask_quiet: assert property ((msk_ff == 8'h00) [*5] |-> !irq)
      else $error("masked interrupt raised");
   a_reset_idle: assert property ($rose(aresetn)
      |-> !xfer_active && !irq && dst_addr == 32'h0)
      else $error("outputs not idle after reset");
endmodule // dcp_channel_checker
bind dcp_channel dcp_channel_checker u_chk (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
   .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .arvalid(arvalid),
   .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata), .beat_done(beat_done),
   .dst_addr(dst_addr), .xfer_active(xfer_active), .irq(irq)
);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
   logic arvalid = '0, rready = '0, beat_done = '0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
   logic [3:0] wstrb = 4'hf;
   logic [7:0] beat_byte = 8'h00;
   logic awready, wready, bvalid, arready, rvalid, xfer_active, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, dst_addr;
   int n_mismatch = 0, checks_done = 0;
   logic [7:0] sts [4] = '{8'h44, 8'h94, 8'h44, 8'hac};
   always #12.5 aclk = ~aclk;
   dcp_channel DUT (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .beat_done(beat_done),
      .beat_byte(beat_byte), .dst_addr(dst_addr), .xfer_active(xfer_active), .irq(irq)
   );
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= {26'h0, a};
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      while (bvalid !== 1'b1) @(posedge aclk);
      cmp({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {26'h0, a};
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      cmp(rdata & m, e);
      cmp({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask
   // Beats are offered only once the cell is running, since idle beats are dropped.
   task automatic beats(input int n);
      while (xfer_active !== 1'b1) @(posedge aclk);
      repeat (n) begin
         beat_done <= 1'b1;
         beat_byte <= beat_byte + 8'h01;
         @(posedge aclk);
      end
      beat_done <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #1500000;
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) rd(6'(4 * i), 32'h0);
      $display("reset values done");
      wr(dcp_pkg::OFF_DST_ADDR, 32'ha5a5_1234);
      rd(dcp_pkg::OFF_DST_ADDR, 32'ha5a5_1234);
      cmp(dst_addr, 32'ha5a5_1234);
      wr(dcp_pkg::OFF_SRC_SIZE, 32'hffff_0003);
      rd(dcp_pkg::OFF_SRC_SIZE, 32'h0000_0003);
      wr(dcp_pkg::OFF_SRC_PTR, 32'h0000_1234);
      rd(dcp_pkg::OFF_SRC_PTR, 32'h0);
      wr(6'h3c, 32'h1, dcp_pkg::RESP_SLVERR);
      rd(6'h3c, 32'h0, 32'hffff_ffff, dcp_pkg::RESP_SLVERR);
      $display("register access done");
      wr(dcp_pkg::OFF_SRC_SIZE, 32'h4);
      wr(dcp_pkg::OFF_DST_SIZE, 32'h8);
      wr(dcp_pkg::OFF_CELL_SIZE, 32'h2);
      for (int i = 0; i < 4; i++) begin
         wr(dcp_pkg::OFF_CTRL, 32'h15);
         beats(2);
         rd(dcp_pkg::OFF_CELL_PTR, 32'h0);
         rd(dcp_pkg::OFF_SRC_PTR, i[0] ? 32'h0 : 32'h2);
         rd(dcp_pkg::OFF_DST_PTR, 32'((2 * i + 2) % 8));
         rd(dcp_pkg::OFF_STATUS, {24'h0, sts[i]});
         if (i == 0) begin
            cmp({31'h0, irq}, 32'h0);
            wr(dcp_pkg::OFF_MASK, 32'hff);
            repeat (3) @(posedge aclk);
         end
         cmp({31'h0, irq}, 32'h1);
         wr(dcp_pkg::OFF_STATUS, {24'h0, sts[i]});
         repeat (3) @(posedge aclk);
         cmp({31'h0, irq}, 32'h0);
      end
      $display("block transfer done");
      wr(dcp_pkg::OFF_SRC_SIZE, 32'h0);
      wr(dcp_pkg::OFF_DST_SIZE, 32'h0);
      wr(dcp_pkg::OFF_CELL_SIZE, 32'h0);
      wr(dcp_pkg::OFF_CTRL, 32'h45);
      beats(16384);
      rd(dcp_pkg::OFF_STATUS, 32'hfc);
      rd(dcp_pkg::OFF_SRC_PTR, 32'h0);
      wr(dcp_pkg::OFF_STATUS, 32'hfc);
      $display("full size done");
      wr(dcp_pkg::OFF_SRC_SIZE, 32'h8);
      wr(dcp_pkg::OFF_DST_SIZE, 32'h8);
      wr(dcp_pkg::OFF_CELL_SIZE, 32'h8);
      wr(dcp_pkg::OFF_MATCH, 32'h5a);
      wstrb <= 4'he;
      wr(dcp_pkg::OFF_MATCH, 32'h0000_0011);
      wstrb <= 4'hf;
      rd(dcp_pkg::OFF_MATCH, 32'h5a);
      beat_byte <= 8'h57;
      wr(dcp_pkg::OFF_CTRL, 32'h17);
      beats(3);
      rd(dcp_pkg::OFF_SRC_PTR, 32'h0);
      rd(dcp_pkg::OFF_CELL_PTR, 32'h0);
      rd(dcp_pkg::OFF_STATUS, 32'h08, 32'h08);
      $display("pattern match done");
      tally_and_finish();
   end
endmodule // tb_top

// ==== src/dcp_channel.sv ====
`timescale 1ns/1ps
// Functional notes
// - Source size code counts bytes; zero means 65,536.
// - Destination size code counts bytes; zero means 65,536.
// - Source pointer is read-only, resets to zero, ignores writes.
// - Destination pointer is read-only and resets to zero.
// - Pattern match in pattern mode clears source and cell pointers.
// - Each start event with enable set moves cell-size bytes; zero means 65,536.
// - Cell pointer is read-only, counts cell bytes, resets to zero.
// - Upper sixteen bits of size and pointer registers read zero, ignore writes.
// - Block done when larger size has moved or a pattern matches.
// - Source done at source size; half flags at half of source and destination sizes.
// - Cell done flag each time one cell has been moved.
module dcp_channel (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Data path: one beat moved and its byte for pattern compare
   input wire logic beat_done,
   input wire logic [7:0] beat_byte,
   // Channel outputs
   output logic [31:0] dst_addr,
   output logic xfer_active,
   output logic irq
);

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [5:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] dest_start_addr;
      logic [31:0] ctrl;
      logic [7:0] status;
      logic [7:0] mask;
      dcp_pkg::dcp_cfg_t cfg;
      dcp_pkg::dcp_prog_t prog;
      logic irq;
   } dcp_state_t;

   dcp_state_t st_ff;
   dcp_state_t nxt_st;

   logic [16:0] src_cnt;
   logic [16:0] dst_cnt;
   logic [16:0] cell_cnt;
   logic [15:0] nxt_src;
   logic [15:0] nxt_dst;
   logic [15:0] nxt_cell;
   logic src_done;
   logic src_half;
   logic dst_done;
   logic dst_half;
   logic cell_done;
   logic cell_half_unused;

   dcp_size_decode u_src_dec (.code(st_ff.cfg.src_byte_count), .count(src_cnt));
   dcp_size_decode u_dst_dec (.code(st_ff.cfg.dst_byte_count), .count(dst_cnt));
   dcp_size_decode u_cell_dec (.code(st_ff.cfg.bytes_per_event), .count(cell_cnt));

   dcp_ptr_step u_src_step (
      .ptr(st_ff.prog.src_progress),
      .size(src_cnt),
      .step(st_ff.cfg.step),
      .nxt_ptr(nxt_src),
      .done(src_done),
      .half(src_half)
   );
   dcp_ptr_step u_dst_step (
      .ptr(st_ff.prog.dst_progress),
      .size(dst_cnt),
      .step(st_ff.cfg.step),
      .nxt_ptr(nxt_dst),
      .done(dst_done),
      .half(dst_half)
   );
   dcp_ptr_step u_cell_step (
      .ptr(st_ff.prog.cell_progress),
      .size(cell_cnt),
      .step(st_ff.cfg.step),
      .nxt_ptr(nxt_cell),
      .done(cell_done),
      .half(cell_half_unused)
   );

   // Read mux; size and pointer words carry zeros above bit 15.
   function automatic logic [31:0] read_word(input dcp_state_t s, input logic [5:0] a);
      logic [31:0] v;
      v = dcp_pkg::REG_RESET;
      unique case (a)
         dcp_pkg::OFF_DST_ADDR: v = s.dest_start_addr;
         dcp_pkg::OFF_SRC_SIZE: v = {16'h0000, s.cfg.src_byte_count};
         dcp_pkg::OFF_DST_SIZE: v = {16'h0000, s.cfg.dst_byte_count};
         dcp_pkg::OFF_SRC_PTR: v = {16'h0000, s.prog.src_progress};
         dcp_pkg::OFF_DST_PTR: v = {16'h0000, s.prog.dst_progress};
         dcp_pkg::OFF_CELL_SIZE: v = {16'h0000, s.cfg.bytes_per_event};
         dcp_pkg::OFF_CELL_PTR: v = {16'h0000, s.prog.cell_progress};
         dcp_pkg::OFF_MATCH: v = {24'h000000, s.cfg.match_byte};
         dcp_pkg::OFF_CTRL: v = {s.ctrl[31:4], 1'b0, s.ctrl[2:0]} | {31'h0, s.prog.busy} << 3;
         dcp_pkg::OFF_STATUS: v = {24'h000000, s.status};
         dcp_pkg::OFF_MASK: v = {24'h000000, s.mask};
         default: v = dcp_pkg::REG_RESET;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [5:0] a);
      return (a[1:0] == 2'b00) && (a <= dcp_pkg::OFF_MASK);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [31:0] wv;
      logic [7:0] ev;
      logic [7:0] w1c;
      logic start_evt;
      logic match;
      logic wr_go;
      logic blk_end;
      wv = dcp_pkg::REG_RESET;
      ev = 8'h00;
      w1c = 8'h00;
      start_evt = 1'b0;
      match = 1'b0;
      wr_go = 1'b0;
      blk_end = 1'b0;
      nxt_st = st_ff;
      nxt_st.ctrl[dcp_pkg::CTRL_START_BIT] = 1'b0;

      // Address and data are latched independently, in either order.
      if (awvalid && !st_ff.aw_got) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_addr = awaddr[5:0];
      end
      if (wvalid && !st_ff.w_got) begin
         nxt_st.w_got = 1'b1;
         nxt_st.w_data = wdata;
         nxt_st.w_strb = wstrb;
      end
      if (st_ff.bvalid && bready) begin
         nxt_st.bvalid = 1'b0;
      end
      wr_go = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
      if (wr_go) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = mapped(st_ff.aw_addr) ? dcp_pkg::RESP_OKAY : dcp_pkg::RESP_SLVERR;
         wv = merge(read_word(st_ff, st_ff.aw_addr), st_ff.w_data, st_ff.w_strb);
         unique case (st_ff.aw_addr)
            dcp_pkg::OFF_DST_ADDR: nxt_st.dest_start_addr = wv;
            dcp_pkg::OFF_SRC_SIZE: nxt_st.cfg.src_byte_count = wv[15:0];
            dcp_pkg::OFF_DST_SIZE: nxt_st.cfg.dst_byte_count = wv[15:0];
            dcp_pkg::OFF_CELL_SIZE: nxt_st.cfg.bytes_per_event = wv[15:0];
            dcp_pkg::OFF_MATCH: nxt_st.cfg.match_byte = wv[7:0];
            dcp_pkg::OFF_CTRL: begin
               // Start is a strobe and is never stored, so it always reads zero.
               nxt_st.ctrl = {25'h0, wv[6:4], 2'b00, wv[1:0]};
               nxt_st.cfg.enable = wv[dcp_pkg::CTRL_EN_BIT];
               nxt_st.cfg.pat_mode = wv[dcp_pkg::CTRL_PAT_BIT];
               nxt_st.cfg.step = (wv[6:4] == 3'h0) ? dcp_pkg::STEP_RESET : wv[6:4];
               start_evt = wv[dcp_pkg::CTRL_START_BIT];
            end
            dcp_pkg::OFF_STATUS: w1c = wv[7:0];
            dcp_pkg::OFF_MASK: nxt_st.mask = wv[7:0];
            default: begin
               // Pointer words are read-only; writes land nowhere.
            end
         endcase
      end

      if (st_ff.rvalid && rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = read_word(st_ff, araddr[5:0]);
         nxt_st.rresp = mapped(araddr[5:0]) ? dcp_pkg::RESP_OKAY : dcp_pkg::RESP_SLVERR;
      end

      // A start event opens one cell of bytes_per_event bytes.
      // The enable written in the same word counts, so one write can enable and start.
      if (start_evt && nxt_st.cfg.enable) begin
         nxt_st.prog.busy = 1'b1;
      end

      if (st_ff.prog.busy && beat_done) begin
         match = st_ff.cfg.pat_mode && (beat_byte == st_ff.cfg.match_byte);
         nxt_st.prog.src_progress = nxt_src;
         nxt_st.prog.dst_progress = nxt_dst;
         nxt_st.prog.cell_progress = nxt_cell;
         ev[dcp_pkg::FLG_SRC_DONE] = src_done;
         ev[dcp_pkg::FLG_SRC_HALF] = src_half;
         ev[dcp_pkg::FLG_DST_DONE] = dst_done;
         ev[dcp_pkg::FLG_DST_HALF] = dst_half;
         // The larger size finishes last, so block end is the wrap of the side with the larger size alone.
         blk_end = (src_cnt >= dst_cnt) ? src_done : dst_done;
         if (cell_done) begin
            ev[dcp_pkg::FLG_CELL] = 1'b1;
            nxt_st.prog.busy = 1'b0;
         end
         if (blk_end || match) begin
            ev[dcp_pkg::FLG_BLOCK] = 1'b1;
            nxt_st.prog.busy = 1'b0;
            nxt_st.prog.dst_progress = dcp_pkg::PTR_RESET;
            nxt_st.prog.src_progress = dcp_pkg::PTR_RESET;
            nxt_st.prog.cell_progress = dcp_pkg::PTR_RESET;
         end
         if (match) begin
            nxt_st.prog.src_progress = dcp_pkg::PTR_RESET;
            nxt_st.prog.cell_progress = dcp_pkg::PTR_RESET;
         end
      end

      // Flags set by hardware win over a simultaneous write-one clear.
      nxt_st.status = (st_ff.status & ~w1c) | ev;
      nxt_st.irq = |(nxt_st.status & nxt_st.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.cfg.step <= dcp_pkg::STEP_RESET;
         st_ff.prog.src_progress <= dcp_pkg::PTR_RESET;
         st_ff.prog.dst_progress <= dcp_pkg::PTR_RESET;
         st_ff.prog.cell_progress <= dcp_pkg::PTR_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign awready = !st_ff.aw_got;
   assign wready = !st_ff.w_got;
   assign bvalid = st_ff.bvalid;
   assign bresp = st_ff.bresp;
   assign arready = !st_ff.rvalid;
   assign rvalid = st_ff.rvalid;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;
   assign dst_addr = st_ff.dest_start_addr;
   assign xfer_active = st_ff.prog.busy;
   assign irq = st_ff.irq;

endmodule // dcp_channel

// ==== src/dcp_ptr_step.sv ====
`timescale 1ns/1ps
// Advances a pointer by step and reports wrap at size and crossing of half size.
module dcp_ptr_step (
   // Inputs
   input wire logic [15:0] ptr,
   input wire logic [16:0] size,
   input wire logic [2:0] step,
   // Results
   output logic [15:0] nxt_ptr,
   output logic done,
   output logic half
);
   logic [16:0] sum;
   logic [16:0] mid;
   always_comb begin
      sum = {1'b0, ptr} + {14'h0000, step};
      mid = {1'b0, size[16:1]};
      done = (sum >= size);
      half = ({1'b0, ptr} < mid) && (sum >= mid);
      // A short final beat still lands the pointer at zero.
      nxt_ptr = done ? 16'h0000 : sum[15:0];
   end
endmodule // dcp_ptr_step

// ==== src/dcp_size_decode.sv ====
`timescale 1ns/1ps
// Expands a 16-bit size code to a 17-bit byte count; all-zero means 65,536.
module dcp_size_decode (
   // Code
   input wire logic [15:0] code,
   // Count
   output logic [16:0] count
);
   always_comb begin
      count = (code == 16'h0000) ? 17'h10000 : {1'b0, code};
   end
endmodule // dcp_size_decode
